// *** core/hnfd_pkg.sv ***
// Purpose: shared constants and carrier types for the hardener no-flow detector
// Assumes: 10 MHz system clock; loop current arrives as a digitised code in microamps
// Notes:   all currents are in uA, all times in ms unless the name says otherwise
package hnfd_pkg;
   // clock and sampling
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned SAMPLE_PERIOD_US = 1000;
   localparam int unsigned SAMPLE_CYCLES    = (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;
   localparam int unsigned TICK_CNT_W       = 16;

   // data widths
   localparam int unsigned CUR_W            = 16;
   localparam int unsigned TIME_W           = 16;

   // no-flow time added per sample tick
   localparam logic [TIME_W-1:0] MS_PER_TICK = TIME_W'(SAMPLE_PERIOD_US / 1000);
   localparam logic [TIME_W-1:0] TIME_MAX    = 16'hffff;
   localparam logic [TIME_W-1:0] TIMER_RST   = 16'h0000;

   // valid span of the current loop, 4 mA to 20 mA
   localparam logic [CUR_W-1:0] LOOP_MIN_UA  = 16'h0fa0;
   localparam logic [CUR_W-1:0] LOOP_MAX_UA  = 16'h4e20;
   localparam logic [CUR_W-1:0] CUR_RST      = 16'h0000;

   // recommended starting settings: 4 s, 6 mA, 10 mA, 100 ms margin
   localparam logic [TIME_W-1:0] DEF_DELAY_MS    = 16'h0fa0;
   localparam logic [CUR_W-1:0]  DEF_NO_FLOW_UA  = 16'h1770;
   localparam logic [CUR_W-1:0]  DEF_FLOW_ON_UA  = 16'h2710;
   localparam logic [TIME_W-1:0] MIN_MARGIN_MS   = 16'h0064;

   // slope of successive samples
   typedef enum logic [1:0] {
      HNFD_SLOPE_STEADY  = 2'b00,
      HNFD_SLOPE_RISING  = 2'b01,
      HNFD_SLOPE_FALLING = 2'b10
   } hnfd_slope_t;

   // detector states
   typedef enum logic [1:0] {
      HNFD_ST_IDLE   = 2'b00,
      HNFD_ST_FLOW   = 2'b01,
      HNFD_ST_NOFLOW = 2'b10,
      HNFD_ST_FAULT  = 2'b11
   } hnfd_state_t;

   // settings from the channel controller
   typedef struct packed {
      logic [CUR_W-1:0]  flow_on_ua;
      logic [CUR_W-1:0]  no_flow_ua;
      logic [TIME_W-1:0] delay_ms;
   } hnfd_cfg_t;

   // status back to the channel controller
   typedef struct packed {
      logic        flowing;
      logic        fault;
      logic        range_err;
      logic        cfg_err;
      hnfd_slope_t slope;
   } hnfd_status_t;
endpackage : hnfd_pkg

// *** core/hnfd_slope.sv ***
// Purpose: compares each loop sample with the one before and reports the slope
// Assumes: sample_stb_i is a one-cycle pulse at the fixed sample rate
// Notes:   the first sample after reset has no predecessor and reads as steady
module hnfd_slope
   import hnfd_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             clk_en_i,
   input  wire logic             sample_stb_i,
   input  wire logic [CUR_W-1:0] sample_i,
   output logic                  stb_o,
   output logic [CUR_W-1:0]      value_o,
   output hnfd_slope_t           slope_o
);
   logic             stb_reg,   stb_next;
   logic [CUR_W-1:0] prev_reg,  prev_next;
   logic             have_reg,  have_next;
   hnfd_slope_t      slope_reg, slope_next;

   // slope from current against previous sample
   always_comb begin
      stb_next   = sample_stb_i;
      prev_next  = prev_reg;
      have_next  = have_reg;
      slope_next = slope_reg;
      if (sample_stb_i) begin
         prev_next = sample_i;
         have_next = 1'b1;
         if (!have_reg || sample_i == prev_reg) begin
            slope_next = HNFD_SLOPE_STEADY;
         end else if (sample_i > prev_reg) begin
            slope_next = HNFD_SLOPE_RISING;
         end else begin
            slope_next = HNFD_SLOPE_FALLING;
         end
      end
   end

   // registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stb_reg   <= 1'b0;
         prev_reg  <= CUR_RST;
         have_reg  <= 1'b0;
         slope_reg <= HNFD_SLOPE_STEADY;
      end else if (clk_en_i) begin
         stb_reg   <= stb_next;
         prev_reg  <= prev_next;
         have_reg  <= have_next;
         slope_reg <= slope_next;
      end
   end

   assign stb_o   = stb_reg;
   assign value_o = prev_reg;
   assign slope_o = slope_reg;
endmodule : hnfd_slope

// *** core/hnfd_detector.sv ***
// Purpose: decides hardener flow from a digitised 4-20 mA loop and raises a no-flow fault
// Assumes: loop code, settings and spray-on are synchronous to clk_i; code is in uA
//          spray_on_i is high while the applicator is triggered
// Notes:   the no-flow timer only runs while spray is on, and carries across spray cycles
//          a decision lands two enabled edges after its sample is captured
//          a code outside the loop span is clamped and flagged, never dropped
//          a bad setting (flow-on not above no-flow) is flagged but still used as given
//          clk_en_i low freezes the tick counter too, so the sample period stretches with it
//
// Overview of operation
// - The flow decision uses only the 4-20 mA loop current measured from the sensor amplifier.
// - A current above the flow-on level is reported as hardener flowing.
// - A current below both the no-flow and the flow-on level is reported as hardener not flowing.
// - A current between the two levels that is rising counts as flowing.
// - A current between the two levels that is steady or falling counts as not flowing.
// - No-flow time is summed in a timer and a fault is raised once it reaches the set delay.
// - The no-flow time keeps adding up over any number of spray on/off cycles.
// - The timer is cleared whenever the current meets or exceeds the flow-on level.
module hnfd_detector
   import hnfd_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              clk_en_i,
   input  wire logic [CUR_W-1:0]  loop_ua_i,
   input  wire hnfd_cfg_t         cfg_i,
   input  wire logic              spray_on_i,
   output hnfd_status_t           status_o,
   output logic [TIME_W-1:0]      no_flow_ms_o,
   output logic                   sample_stb_o
);
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(SAMPLE_CYCLES_P - 1);

   // sample tick generator
   logic [TICK_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
   logic                  tick_reg,     tick_next;

   // captured loop sample
   logic [CUR_W-1:0]      cur_reg,      cur_next;
   logic                  range_reg,    range_next;
   logic                  cap_stb_reg,  cap_stb_next;

   // slope stage results
   logic                  slope_stb;
   logic [CUR_W-1:0]      slope_value;
   hnfd_slope_t           slope_dir;

   // detector state and timer
   hnfd_state_t           state_reg,    state_next;
   logic [TIME_W-1:0]     timer_reg,    timer_next;
   hnfd_status_t          status_reg,   status_next;

   // classification of the latest sample
   logic                  at_flow_on;
   logic                  below_no_flow;
   logic                  seen_flow;
   logic [TIME_W:0]       timer_sum;
   logic [TIME_W-1:0]     timer_add;

   // fixed-period sample tick
   // counts enabled edges only, so a frozen clock enable stretches the period
   // >= rather than == recovers if the count ever lands past the last value
   always_comb begin
      tick_cnt_next = tick_cnt_reg + 16'h0001;
      tick_next     = 1'b0;
      if (tick_cnt_reg >= TICK_LAST) begin
         tick_cnt_next = 16'h0000;
         tick_next     = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_reg <= 16'h0000;
         tick_reg     <= 1'b0;
      end else if (clk_en_i) begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg     <= tick_next;
      end
   end

   // capture the loop code, clamping it into the 4-20 mA span
   // a broken loop reads as the floor, so it still counts as no flow
   // the range flag is refreshed on every capture and clears once the loop is back in span
   always_comb begin
      cur_next     = cur_reg;
      range_next   = range_reg;
      cap_stb_next = tick_reg;
      if (tick_reg) begin
         range_next = 1'b0;
         if (loop_ua_i < LOOP_MIN_UA) begin
            cur_next   = LOOP_MIN_UA;
            range_next = 1'b1;
         end else if (loop_ua_i > LOOP_MAX_UA) begin
            cur_next   = LOOP_MAX_UA;
            range_next = 1'b1;
         end else begin
            cur_next = loop_ua_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur_reg     <= CUR_RST;
         range_reg   <= 1'b0;
         cap_stb_reg <= 1'b0;
      end else if (clk_en_i) begin
         cur_reg     <= cur_next;
         range_reg   <= range_next;
         cap_stb_reg <= cap_stb_next;
      end
   end

   // slope against the previous sample
   // this stage adds one edge, so a decision lands two edges after capture
   hnfd_slope u_slope (
      .clk_i        (clk_i),
      .reset_n_i    (reset_n_i),
      .clk_en_i     (clk_en_i),
      .sample_stb_i (cap_stb_reg),
      .sample_i     (cur_reg),
      .stb_o        (slope_stb),
      .value_o      (slope_value),
      .slope_o      (slope_dir)
   );

   // flow decision for the sample leaving the slope stage
   // a sample equal to the no-flow level falls in the band and needs a rising slope
   // the thresholds are read live, so new settings act at the next decision
   // a bad setting makes the two tests overlap; the flow-on test then wins
   always_comb begin
      at_flow_on    = (slope_value >= cfg_i.flow_on_ua);
      below_no_flow = (slope_value <  cfg_i.no_flow_ua);
      if (at_flow_on) begin
         seen_flow = 1'b1;
      end else if (below_no_flow) begin
         seen_flow = 1'b0;
      end else if (slope_dir == HNFD_SLOPE_RISING) begin
         seen_flow = 1'b1;
      end else begin
         seen_flow = 1'b0;
      end
   end

   // saturating no-flow time sum
   // saturating keeps a long no-flow spell from wrapping back to zero
   assign timer_add = (timer_sum[TIME_W]) ? TIME_MAX : timer_sum[TIME_W-1:0];
   assign timer_sum = {1'b0, timer_reg} + {1'b0, MS_PER_TICK};

   // state, timer and status
   always_comb begin
      state_next  = state_reg;
      timer_next  = timer_reg;
      status_next = status_reg;
      // both flags follow their sources on every enabled edge, not only at decisions
      status_next.range_err = range_reg;
      status_next.cfg_err   = (cfg_i.flow_on_ua <= cfg_i.no_flow_ua);
      if (slope_stb) begin
         status_next.slope   = slope_dir;
         status_next.flowing = seen_flow;
         // spray off holds the timer unless the sample is at flow-on; a rising sample in the band neither clears nor adds
         if (at_flow_on) begin
            timer_next = TIMER_RST;
         end else if (!seen_flow && spray_on_i) begin
            timer_next = timer_add;
         end
         case (state_reg)
            HNFD_ST_IDLE,
            HNFD_ST_FLOW,
            HNFD_ST_NOFLOW: begin
               // fault is judged on the sum being written, so a zero delay faults at once
               if (at_flow_on || seen_flow) begin
                  state_next = HNFD_ST_FLOW;
               end else if (spray_on_i && timer_add >= cfg_i.delay_ms) begin
                  state_next = HNFD_ST_FAULT;
               end else begin
                  state_next = HNFD_ST_NOFLOW;
               end
            end
            HNFD_ST_FAULT: begin
               // only a clearing sample lets the fault go
               // a rising sample inside the band leaves it raised
               if (at_flow_on) begin
                  state_next = HNFD_ST_FLOW;
               end
            end
            default: begin
               // an unused code falls back to idle
               state_next = HNFD_ST_IDLE;
            end
         endcase
         status_next.fault = (state_next == HNFD_ST_FAULT);
      end
   end

   // state, timer and status registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg  <= HNFD_ST_IDLE;
         timer_reg  <= TIMER_RST;
         status_reg <= '0;
      end else if (clk_en_i) begin
         state_reg  <= state_next;
         timer_reg  <= timer_next;
         status_reg <= status_next;
      end
   end

   // outputs straight from flops
   // nothing combinational reaches the pins, so the far side sees clean levels
   assign status_o     = status_reg;
   assign no_flow_ms_o = timer_reg;
   assign sample_stb_o = slope_stb;
endmodule : hnfd_detector

// *** dv/hnfd_monitor.sv ***
// Purpose: port checks on the no-flow detector
// Assumes: decided sample was captured one enabled edge before the strobe
// Notes:   bound to every hnfd_detector
module hnfd_monitor
   import hnfd_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
   input wire logic              clk_i,
   input wire logic              reset_n_i,
   input wire logic              clk_en_i,
   input wire logic [CUR_W-1:0]  loop_ua_i,
   input wire hnfd_cfg_t         cfg_i,
   input wire logic              spray_on_i,
   input wire hnfd_status_t      status_o,
   input wire logic [TIME_W-1:0] no_flow_ms_o,
   input wire logic              sample_stb_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CUR_W-1:0] pipe_reg;
   logic [CUR_W-1:0] cap_reg;
   logic [CUR_W-1:0] last_reg;
   logic             seen_reg;
   logic [15:0]      gap_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // track the sample under decision, the one before it, and the tick spacing
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pipe_reg <= '0;
         cap_reg  <= '0;
         last_reg <= '0;
         seen_reg <= 1'b0;
         gap_reg  <= '0;
      end else if (clk_en_i) begin
         pipe_reg <= loop_ua_i;
         cap_reg  <= pipe_reg;
         gap_reg  <= sample_stb_o ? 16'h0000 : gap_reg + 16'h0001;
         if (sample_stb_o) begin
            last_reg <= cap_reg;
            seen_reg <= 1'b1;
         end
      end
   end
   // a decision cycle that meets a condition on the sample
   sequence s_dec(c);
      sample_stb_o && clk_en_i && c;
   endsequence
   property p_flow_hi;
      s_dec(cap_reg > cfg_i.flow_on_ua) |=> status_o.flowing;
   endproperty
   a_flow_hi: assert property (p_flow_hi) else $error("no flow above flow-on");
   property p_flow_lo;
      s_dec(cap_reg < cfg_i.no_flow_ua) |=> !status_o.flowing;
   endproperty
   a_flow_lo: assert property (p_flow_lo) else $error("flow below no-flow");
   property p_band;
      s_dec(cap_reg >= cfg_i.no_flow_ua && cap_reg < cfg_i.flow_on_ua)
         |=> status_o.flowing == (status_o.slope == HNFD_SLOPE_RISING);
   endproperty
   a_band: assert property (p_band) else $error("in-band decision wrong");
   property p_slope;
      s_dec(seen_reg && cap_reg > last_reg && cap_reg <= LOOP_MAX_UA && last_reg >= LOOP_MIN_UA)
         |=> status_o.slope == HNFD_SLOPE_RISING;
   endproperty
   a_slope: assert property (p_slope) else $error("rise not seen");
   property p_clear;
      s_dec(cap_reg >= cfg_i.flow_on_ua) |=> no_flow_ms_o == TIMER_RST && !status_o.fault;
   endproperty
   a_clear: assert property (p_clear) else $error("timer not cleared");
   property p_accum;
      s_dec(cap_reg < cfg_i.no_flow_ua && spray_on_i && no_flow_ms_o != TIME_MAX)
         |=> no_flow_ms_o == $past(no_flow_ms_o) + MS_PER_TICK;
   endproperty
   a_accum: assert property (p_accum) else $error("timer not adding");
   property p_hold;
      s_dec(!spray_on_i && cap_reg < cfg_i.flow_on_ua) |=> $stable(no_flow_ms_o);
   endproperty
   a_hold: assert property (p_hold) else $error("timer lost with spray off");
   property p_fault;
      s_dec(cap_reg < cfg_i.no_flow_ua && spray_on_i && no_flow_ms_o != TIME_MAX
            && no_flow_ms_o + MS_PER_TICK >= cfg_i.delay_ms) |=> status_o.fault;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not raised");
   property p_sticky;
      status_o.fault && !(sample_stb_o && cap_reg >= cfg_i.flow_on_ua) |=> status_o.fault;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fault dropped");
   property p_period;
      s_dec(seen_reg) |-> gap_reg == 16'(SAMPLE_CYCLES_P - 1) ##1 !sample_stb_o;
   endproperty
   a_period: assert property (p_period) else $error("sample spacing wrong");
   property p_range;
      s_dec(1'b1) |-> status_o.range_err == (cap_reg < LOOP_MIN_UA || cap_reg > LOOP_MAX_UA);
   endproperty
   a_range: assert property (p_range) else $error("range flag wrong");
   property p_cfg;
      clk_en_i |=> status_o.cfg_err == ($past(cfg_i.flow_on_ua) <= $past(cfg_i.no_flow_ua));
   endproperty
   a_cfg: assert property (p_cfg) else $error("setting flag wrong");
   property p_freeze;
      !clk_en_i |=> $stable(status_o) && $stable(no_flow_ms_o) && $stable(sample_stb_o);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : hnfd_monitor

bind hnfd_detector hnfd_monitor #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)) u_mon (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .loop_ua_i(loop_ua_i), .cfg_i(cfg_i),
   .spray_on_i(spray_on_i), .status_o(status_o), .no_flow_ms_o(no_flow_ms_o), .sample_stb_o(sample_stb_o));

// *** dv/hnfd_amp_model.sv ***
// Purpose: loop output of the flow sensor amplifier
// Assumes: target is set by the bench, outside the loop span only in the range-flag test
// Notes:   slow mode slews 2 mA per clock, like a lagging sensor
module hnfd_amp_model
   import hnfd_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             slow_i,
   input  wire logic [CUR_W-1:0] target_ua_i,
   output logic      [CUR_W-1:0] loop_ua_o
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [CUR_W-1:0] SLEW_UA = 16'h07d0;
   logic [CUR_W-1:0] gap;
   // loop starts at the 4 mA floor
   initial loop_ua_o = LOOP_MIN_UA;
   // move toward the target, at once or slew limited
   always @(posedge clk_i) begin
      gap = (target_ua_i > loop_ua_o) ? target_ua_i - loop_ua_o : loop_ua_o - target_ua_i;
      if (!slow_i || gap <= SLEW_UA) begin
         loop_ua_o <= target_ua_i;
      end else begin
         loop_ua_o <= (target_ua_i > loop_ua_o) ? loop_ua_o + SLEW_UA : loop_ua_o - SLEW_UA;
      end
   end
endmodule : hnfd_amp_model

// *** dv/testbench.sv ***
// Purpose: self-checking bench for the no-flow detector
// Assumes: short sample period, one decision per step
// Notes:   inputs change on the falling edge
module testbench
   import hnfd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned TICKS_P = 10;
   logic              clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              slow = 1'b0;
   logic              spray = 1'b0;
   logic              clk_en = 1'b1;
   logic [CUR_W-1:0]  target_ua = LOOP_MIN_UA;
   logic [CUR_W-1:0]  loop_ua;
   hnfd_cfg_t         cfg = '{DEF_FLOW_ON_UA, DEF_NO_FLOW_UA, DEF_DELAY_MS};
   hnfd_status_t      status;
   logic [TIME_W-1:0] ms;
   logic              stb;
   int                miscompares = 0;
   int                compares = 0;
   // 10 MHz clock
   always #50 clk = ~clk;
   hnfd_amp_model u_amp (.clk_i(clk), .slow_i(slow), .target_ua_i(target_ua), .loop_ua_o(loop_ua));
   hnfd_detector #(.SAMPLE_CYCLES_P(TICKS_P)) u_dut (.clk_i(clk), .reset_n_i(reset_n), .clk_en_i(clk_en),
      .loop_ua_i(loop_ua), .cfg_i(cfg), .spray_on_i(spray), .status_o(status), .no_flow_ms_o(ms),
      .sample_stb_o(stb));
   task automatic give_verdict();
      $display("counts: %0d compares, %0d miscompares", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // drive one level, wait for its decision, then judge the update
   task automatic step(input logic [15:0] ua, input logic spr, input logic fl, input logic ft,
                       input logic [15:0] nf);
      int n;
      n = 0;
      target_ua = ua;
      spray = spr;
      while (stb !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      if (stb !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: no strobe", $time);
         return;
      end
      @(negedge clk);
      chk("strobe", 16'(stb), 16'h0000);
      chk("flowing", 16'(status.flowing), 16'(fl));
      chk("fault", 16'(status.fault), 16'(ft));
      chk("timer", ms, nf);
   endtask : step
   task automatic t_levels();
      cfg = '{DEF_FLOW_ON_UA, DEF_NO_FLOW_UA, DEF_DELAY_MS};
      step(16'h2ee0, 1'b1, 1'b1, 1'b0, 16'h0000);
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0001);
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0002);
      step(DEF_FLOW_ON_UA, 1'b1, 1'b1, 1'b0, 16'h0000);
      $display("test levels done");
   endtask : t_levels
   task automatic t_band();
      slow = 1'b1;
      step(16'h1b58, 1'b1, 1'b0, 1'b0, 16'h0001);
      chk("slope", 16'(status.slope), 16'(HNFD_SLOPE_FALLING));
      step(16'h1f40, 1'b1, 1'b1, 1'b0, 16'h0001);
      chk("slope", 16'(status.slope), 16'(HNFD_SLOPE_RISING));
      step(16'h1f40, 1'b1, 1'b0, 1'b0, 16'h0002);
      chk("slope", 16'(status.slope), 16'(HNFD_SLOPE_STEADY));
      slow = 1'b0;
      $display("test band done");
   endtask : t_band
   task automatic t_fault();
      cfg.delay_ms = 16'h0003;
      step(16'h2ee0, 1'b1, 1'b1, 1'b0, 16'h0000);
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0001);
      step(16'h1388, 1'b0, 1'b0, 1'b0, 16'h0001);
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0002);
      step(16'h1388, 1'b1, 1'b0, 1'b1, 16'h0003);
      step(16'h1388, 1'b1, 1'b0, 1'b1, 16'h0004);
      step(16'h1b58, 1'b1, 1'b1, 1'b1, 16'h0004);
      step(16'h2ee0, 1'b1, 1'b1, 1'b0, 16'h0000);
      $display("test fault done");
   endtask : t_fault
   // out-of-span codes are clamped and flagged, a bad setting is flagged
   task automatic t_flags();
      step(16'h5208, 1'b1, 1'b1, 1'b0, 16'h0000);
      chk("range", 16'(status.range_err), 16'h0001);
      step(16'h0bb8, 1'b0, 1'b0, 1'b0, 16'h0000);
      chk("range", 16'(status.range_err), 16'h0001);
      cfg.flow_on_ua = DEF_NO_FLOW_UA;
      @(negedge clk);
      chk("cfg", 16'(status.cfg_err), 16'h0001);
      cfg.flow_on_ua = DEF_FLOW_ON_UA;
      @(negedge clk);
      chk("cfg", 16'(status.cfg_err), 16'h0000);
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0001);
      chk("range", 16'(status.range_err), 16'h0000);
      $display("test flags done");
   endtask : t_flags
   // clock enable low: a flowing level must not be taken, the timer must not move
   task automatic t_freeze();
      int k;
      k = 0;
      clk_en = 1'b0;
      target_ua = 16'h2ee0;
      repeat (30) begin
         @(negedge clk);
         if (stb !== 1'b0) begin
            k++;
         end
      end
      chk("frozen strobes", 16'(k), 16'h0000);
      chk("frozen timer", ms, 16'h0001);
      chk("frozen flow", 16'(status.flowing), 16'h0000);
      clk_en = 1'b1;
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0002);
      $display("test freeze done");
   endtask : t_freeze
   // a raised fault and a running timer are dropped by a reset in mid-run
   task automatic t_reset();
      step(16'h1388, 1'b1, 1'b0, 1'b1, 16'h0003);
      reset_n = 1'b0;
      @(negedge clk);
      chk("reset status", 16'(status), 16'h0000);
      chk("reset timer", ms, 16'h0000);
      chk("reset strobe", 16'(stb), 16'h0000);
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      step(16'h1388, 1'b1, 1'b0, 1'b0, 16'h0001);
      $display("test reset done");
   endtask : t_reset
   // reset for 10 cycles, then the scenarios
   initial begin
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      t_levels();
      t_band();
      t_fault();
      t_flags();
      t_freeze();
      t_reset();
      give_verdict();
   end
endmodule : testbench
